// ---- rtl/sar_pkg.sv ----
// Constants for the system memory arbiter
package sar_pkg;
    localparam int          SAR_NREQ       = 9;      // Interrupt, main, six DMA, scanner
    localparam int          SAR_NPER       = 7;      // Peripheral requestors
    localparam int          SAR_PW         = 3;      // Priority field width
    localparam logic [2:0]  SAR_PRIO_RST   = 3'h7;   // Least urgent level
    localparam logic [3:0]  SAR_IDX_ISR    = 4'h0;   // Tie order position of interrupt context
    localparam logic [3:0]  SAR_IDX_MAIN   = 4'h1;   // Tie order position of main context
    localparam logic [3:0]  SAR_IDX_PER0   = 4'h2;   // Tie order position of DMA channel 1
    // Register byte addresses
    localparam logic [7:0]  SAR_OFS_PRIO0  = 8'h00;  // Priority settings at 0x00..0x20
    localparam logic [7:0]  SAR_OFS_LOCK   = 8'h24;  // Priority lock register
    localparam logic [7:0]  SAR_OFS_STAT   = 8'h28;  // Grant and stall status
    localparam int          SAR_LOCK_BIT   = 0;      // Lock bit position
    localparam logic [7:0]  SAR_KEY1       = 8'h55;  // First unlock code
    localparam logic [7:0]  SAR_KEY2       = 8'hAA;  // Second unlock code
    // Memory targets of a peripheral request
    localparam logic [1:0]  SAR_TGT_FLASH  = 2'h0;
    localparam logic [1:0]  SAR_TGT_DATA   = 2'h1;
    localparam logic [1:0]  SAR_TGT_EEPROM = 2'h2;
    localparam logic [1:0]  SAR_RESP_OKAY  = 2'h0;
    localparam logic [1:0]  SAR_RESP_SLVERR = 2'h2;
    // Lock sequence states, Gray coded
    typedef enum logic [1:0] {
        SAR_SEQ_IDLE  = 2'b00,
        SAR_SEQ_GOT1  = 2'b01,
        SAR_SEQ_ARMED = 2'b11
    } sar_seq_e;
endpackage : sar_pkg

// ---- rtl/sar_arbiter.sv ----
// System memory arbiter with AXI4-Lite register slave
// Overview of operation
// - Requestors rank by their priority value, zero most urgent, larger less urgent.
// - After reset all nine priority settings hold 7, the least urgent level.
// - Equal values resolve in order interrupt, main, DMA 1 to 6, then scanner.
// - Each of the nine requestors has its own independently writable priority setting.
// - DMA channels and scanner get grants only while the lock bit is set.
// - While locked, priority settings hold and writes to them are ignored.
// - The lock bit changes only after writes of 0x55 then 0xAA to the lock register.
// - A peripheral below the CPU uses flash only in cycles without CPU flash use or flash operation.
// - A peripheral below the CPU uses data RAM or registers only in cycles the CPU leaves free.
// - A peripheral below the CPU reaches EEPROM at once unless an EEPROM operation runs.
// - Peripherals below the CPU never lengthen CPU execution.
// - A peripheral above the CPU stalls the CPU until its operation finishes.
// - Interrupt above peripheral above main lets both stall main; interrupt preempts peripheral.
// - A low peripheral uses only cycles free of every higher requestor, peripherals included.
// - Unimplemented register bits read zero and ignore writes.
module sar_arbiter (
    input  wire logic                           aclk,
    input  wire logic                           aresetn,
    // AXI4-Lite slave
    input  wire logic [7:0]                     s_axi_awaddr,
    input  wire logic                           s_axi_awvalid,
    output logic                                s_axi_awready,
    input  wire logic [31:0]                    s_axi_wdata,
    input  wire logic [3:0]                     s_axi_wstrb,
    input  wire logic                           s_axi_wvalid,
    output logic                                s_axi_wready,
    output logic [1:0]                          s_axi_bresp,
    output logic                                s_axi_bvalid,
    input  wire logic                           s_axi_bready,
    input  wire logic [7:0]                     s_axi_araddr,
    input  wire logic                           s_axi_arvalid,
    output logic                                s_axi_arready,
    output logic [31:0]                         s_axi_rdata,
    output logic [1:0]                          s_axi_rresp,
    output logic                                s_axi_rvalid,
    input  wire logic                           s_axi_rready,
    // CPU side
    input  wire logic                           cpu_isr_active,
    input  wire logic                           cpu_flash_access,
    input  wire logic                           cpu_data_access,
    output logic                                cpu_stall,
    // Memory operation status
    input  wire logic                           flash_op_busy,
    input  wire logic                           eeprom_op_busy,
    // Peripheral requestors (DMA 1..6, scanner)
    input  wire logic [sar_pkg::SAR_NPER-1:0]   per_req,
    input  wire logic [2*sar_pkg::SAR_NPER-1:0] per_target,
    output logic [sar_pkg::SAR_NPER-1:0]        per_grant
);
    import sar_pkg::*;

    // Priority settings: 0 interrupt, 1 main, 2 to 8 peripherals
    logic [SAR_PW-1:0]   prio_r   [SAR_NREQ];
    logic [SAR_PW-1:0]   prio_nxt [SAR_NREQ];

    // Lock bit and unlock key sequence
    logic                lock_r;
    logic                lock_nxt;
    sar_seq_e            seq_r;
    sar_seq_e            seq_nxt;

    // Write address and data, held until both are in
    logic                aw_hold_r;
    logic                aw_hold_nxt;
    logic                w_hold_r;
    logic                w_hold_nxt;
    logic [7:0]          waddr_r;
    logic [7:0]          waddr_nxt;
    logic [31:0]         wdata_r;
    logic [31:0]         wdata_nxt;
    logic                wstrb0_r;
    logic                wstrb0_nxt;
    logic                do_write;

    // Write response
    logic                bvalid_r;
    logic                bvalid_nxt;
    logic [1:0]          bresp_r;
    logic [1:0]          bresp_nxt;

    // Read response
    logic                rvalid_r;
    logic                rvalid_nxt;
    logic [31:0]         rdata_r;
    logic [31:0]         rdata_nxt;
    logic [1:0]          rresp_r;
    logic [1:0]          rresp_nxt;

    // Arbitration; a key is {priority, tie order}, smaller wins
    logic [6:0]          cpu_key;
    logic [6:0]          per_key  [SAR_NPER];
    logic [SAR_NPER-1:0] per_high;
    logic [SAR_NPER-1:0] per_elig;
    logic                win_any;
    logic [2:0]          win_idx;
    logic [6:0]          win_key;

    // Bus handshakes
    assign s_axi_awready = !aw_hold_r && !bvalid_r;
    assign s_axi_wready  = !w_hold_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign do_write      = aw_hold_r && w_hold_r && !bvalid_r;

    // Arbitration is combinational: grant and stall follow the inputs
    // in the same cycle; a requestor holds per_req until its operation
    // is done, so a stall lasts exactly as long as that operation

    // Urgency key of the running CPU context: value first, tie order second
    assign cpu_key = cpu_isr_active ? {prio_r[0], SAR_IDX_ISR}
                                    : {prio_r[1], SAR_IDX_MAIN};

    // Per peripheral key and eligibility
    for (genvar g = 0; g < SAR_NPER; g++) begin : g_per
        logic [1:0] tgt;
        logic       busy;
        logic       cpu_uses;
        // Target and urgency of this request
        assign tgt      = per_target[2*g +: 2];
        assign per_key[g] = {prio_r[g+2], SAR_IDX_PER0 + 4'(g)};
        assign per_high[g] = per_key[g] < cpu_key;
        // Memory busy, or CPU on the same memory
        assign busy = ((tgt == SAR_TGT_FLASH) && flash_op_busy)
                   || ((tgt == SAR_TGT_EEPROM) && eeprom_op_busy);
        assign cpu_uses = ((tgt == SAR_TGT_FLASH) && cpu_flash_access)
                       || ((tgt == SAR_TGT_DATA) && cpu_data_access);
        // Low peripherals only in cycles the CPU leaves free
        assign per_elig[g] = lock_r && per_req[g] && !busy
                          && (per_high[g] || !cpu_uses);
    end

    // Most urgent eligible peripheral wins the cycle
    always_comb begin
        win_any = 1'b0;
        win_idx = 3'h0;
        win_key = 7'h7F;
        for (int j = 0; j < SAR_NPER; j++) begin
            // Strict less-than keeps the earlier tie order
            if (per_elig[j] && (!win_any || per_key[j] < win_key)) begin
                win_any = 1'b1;
                win_idx = 3'(j);
                win_key = per_key[j];
            end
        end
    end

    // Grant and CPU stall
    always_comb begin
        per_grant = '0;
        if (win_any) begin
            per_grant[win_idx] = 1'b1;
        end
        // Stall only when the winner outranks the running context
        cpu_stall = win_any && per_high[win_idx];
    end

    // Write channel, lock sequence and priority settings
    always_comb begin
        // Hold every register by default
        aw_hold_nxt = aw_hold_r;
        w_hold_nxt  = w_hold_r;
        waddr_nxt   = waddr_r;
        wdata_nxt   = wdata_r;
        wstrb0_nxt  = wstrb0_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        lock_nxt    = lock_r;
        seq_nxt     = seq_r;
        for (int k = 0; k < SAR_NREQ; k++) begin
            prio_nxt[k] = prio_r[k];
        end
        // Capture address and data, in either order
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_nxt = 1'b1;
            waddr_nxt   = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold_nxt = 1'b1;
            wdata_nxt  = s_axi_wdata;
            wstrb0_nxt = s_axi_wstrb[0];
        end
        // Response accepted
        if (s_axi_bvalid && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        // Both halves in: apply and answer
        if (do_write) begin
            aw_hold_nxt = 1'b0;
            w_hold_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = SAR_RESP_OKAY;
            if (waddr_r[7:2] < 6'(SAR_NREQ) && waddr_r[1:0] == 2'h0) begin
                // Upper bits are not stored
                if (wstrb0_r && !lock_r) begin
                    prio_nxt[waddr_r[5:2]] = wdata_r[SAR_PW-1:0];
                end
            end else if (waddr_r == SAR_OFS_LOCK) begin
                // Key sequence, then the lock bit itself
                if (wstrb0_r) begin
                    unique case (seq_r)
                        SAR_SEQ_IDLE: begin
                            seq_nxt = (wdata_r[7:0] == SAR_KEY1) ? SAR_SEQ_GOT1
                                                                 : SAR_SEQ_IDLE;
                        end
                        SAR_SEQ_GOT1: begin
                            seq_nxt = (wdata_r[7:0] == SAR_KEY2) ? SAR_SEQ_ARMED
                                                                 : SAR_SEQ_IDLE;
                        end
                        SAR_SEQ_ARMED: begin
                            lock_nxt = wdata_r[SAR_LOCK_BIT];
                            seq_nxt  = SAR_SEQ_IDLE;
                        end
                        default: begin
                            seq_nxt = SAR_SEQ_IDLE;
                        end
                    endcase
                end
            end else if (waddr_r != SAR_OFS_STAT) begin
                // Unmapped address
                bresp_nxt = SAR_RESP_SLVERR;
            end
        end
    end

    // Write side registers, synchronous reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            waddr_r   <= 8'h00;
            wdata_r   <= 32'h0000_0000;
            wstrb0_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= SAR_RESP_OKAY;
            lock_r    <= 1'b0;
            seq_r     <= SAR_SEQ_IDLE;
            for (int k = 0; k < SAR_NREQ; k++) begin
                prio_r[k] <= SAR_PRIO_RST;
            end
        end else begin
            aw_hold_r <= aw_hold_nxt;
            w_hold_r  <= w_hold_nxt;
            waddr_r   <= waddr_nxt;
            wdata_r   <= wdata_nxt;
            wstrb0_r  <= wstrb0_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            lock_r    <= lock_nxt;
            seq_r     <= seq_nxt;
            for (int k = 0; k < SAR_NREQ; k++) begin
                prio_r[k] <= prio_nxt[k];
            end
        end
    end

    // Read channel
    always_comb begin
        // Hold the response by default
        rvalid_nxt = rvalid_r;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        if (s_axi_rvalid && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        // New address: decode into the response
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rdata_nxt  = 32'h0000_0000;
            rresp_nxt  = SAR_RESP_OKAY;
            if (s_axi_araddr[7:2] < 6'(SAR_NREQ) && s_axi_araddr[1:0] == 2'h0) begin
                rdata_nxt[SAR_PW-1:0] = prio_r[s_axi_araddr[5:2]];
            end else if (s_axi_araddr == SAR_OFS_LOCK) begin
                rdata_nxt[SAR_LOCK_BIT] = lock_r;
            end else if (s_axi_araddr == SAR_OFS_STAT) begin
                rdata_nxt[SAR_NPER:0] = {cpu_stall, per_grant};
            end else begin
                rresp_nxt = SAR_RESP_SLVERR;
            end
        end
    end

    // Read side registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= SAR_RESP_OKAY;
        end else begin
            rvalid_r <= rvalid_nxt;
            rdata_r  <= rdata_nxt;
            rresp_r  <= rresp_nxt;
        end
    end
endmodule : sar_arbiter

// ---- tb/sar_arbiter_props.sv ----
// Port assertions for the system memory arbiter
module sar_arbiter_props import sar_pkg::*; (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        cpu_flash_access,
    input wire logic        cpu_data_access,
    input wire logic        cpu_stall,
    input wire logic        flash_op_busy,
    input wire logic        eeprom_op_busy,
    input wire logic [6:0]  per_req,
    input wire logic [13:0] per_target,
    input wire logic [6:0]  per_grant
);
    logic [1:0] gnt_tgt;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Target of the granted peripheral, 3 when none
    always_comb begin
        gnt_tgt = 2'h3;
        for (int i = 0; i < 7; i++) begin
            if (per_grant[i]) gnt_tgt = per_target[2*i +: 2];
        end
    end
    a_grant_one_hot: assert property ($onehot0(per_grant))
        else $error("several grants at once");
    a_grant_needs_req: assert property ((per_grant & ~per_req) == 7'h00)
        else $error("grant without request");
    a_flash_op_wait: assert property (gnt_tgt == SAR_TGT_FLASH |-> !flash_op_busy)
        else $error("flash grant during flash operation");
    a_eeprom_op_wait: assert property (gnt_tgt == SAR_TGT_EEPROM |-> !eeprom_op_busy)
        else $error("eeprom grant during eeprom operation");
    a_flash_cpu_free: assert property (
        gnt_tgt == SAR_TGT_FLASH && !cpu_stall |-> !cpu_flash_access)
        else $error("flash cycle taken from cpu");
    a_data_cpu_free: assert property (
        gnt_tgt == SAR_TGT_DATA && !cpu_stall |-> !cpu_data_access)
        else $error("data cycle taken from cpu");
    a_stall_by_grant: assert property (cpu_stall |-> per_grant != 7'h00)
        else $error("stall without a granted peripheral");
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("no write response two cycles after capture");
endmodule : sar_arbiter_props

bind sar_arbiter sar_arbiter_props u_props (.*);

// ---- tb/sar_periph_model.sv ----
// Behavioural DMA channels and scanner facing the arbiter
module sar_periph_model (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [6:0]  want,
    input  wire logic [13:0] want_tgt,
    input  wire logic [6:0]  per_grant,
    output logic      [6:0]  per_req,
    output logic      [13:0] per_target
);
    logic [6:0] done_r;
    logic [6:0] done_nxt;
    // One-cycle operation ends at its grant edge
    always_comb begin
        done_nxt = aresetn ? (want & (done_r | per_grant)) : 7'h00;
    end
    always_ff @(posedge aclk) begin
        done_r <= done_nxt;
    end
    // Request held until served; idle targets show inverted data
    always_comb begin
        per_req = want & ~done_r;
        for (int i = 0; i < 7; i++) begin
            per_target[2*i +: 2] = per_req[i] ? want_tgt[2*i +: 2] : ~want_tgt[2*i +: 2];
        end
    end
endmodule : sar_periph_model

// ---- tb/sar_arbiter_tb_top.sv ----
// Self-checking bench for the system memory arbiter
module sar_arbiter_tb_top import sar_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [4:0]  cpu;
        logic [6:0]  req;
        logic [13:0] tgt;
        logic [6:0]  g;
        logic        st;
    } sar_row_s;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cpu_stall;
    logic cpu_isr_active, cpu_flash_access, cpu_data_access, flash_op_busy, eeprom_op_busy;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [6:0]  per_req, per_grant, want;
    logic [13:0] per_target, want_tgt;
    int          miscompares, comparisons, i;
    logic [2:0]  prio [9] = '{3'h2, 3'h4, 3'h1, 3'h3, 3'h5, 3'h5, 3'h5, 3'h5, 3'h5};
    // cpu = {isr, flash use, data use, flash busy, eeprom busy}
    sar_row_s rows [12] = '{
        '{5'h08, 7'h04, 14'h0000, 7'h00, 1'h0}, '{5'h00, 7'h04, 14'h0000, 7'h04, 1'h0},
        '{5'h02, 7'h04, 14'h0000, 7'h00, 1'h0}, '{5'h04, 7'h04, 14'h0010, 7'h00, 1'h0},
        '{5'h00, 7'h04, 14'h0010, 7'h04, 1'h0}, '{5'h0C, 7'h04, 14'h0020, 7'h04, 1'h0},
        '{5'h01, 7'h04, 14'h0020, 7'h00, 1'h0}, '{5'h08, 7'h01, 14'h0000, 7'h01, 1'h1},
        '{5'h18, 7'h02, 14'h0000, 7'h00, 1'h0}, '{5'h08, 7'h02, 14'h0000, 7'h02, 1'h1},
        '{5'h00, 7'h44, 14'h2020, 7'h04, 1'h0}, '{5'h00, 7'h05, 14'h0000, 7'h01, 1'h1}};
    sar_arbiter DUT (.*);
    sar_periph_model u_per (.*);
    initial begin
        aclk = 1'h0;
        forever #10 aclk = ~aclk;
    end
    task automatic report_and_stop;
        if (miscompares == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop
    task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val
    task automatic chk_arb(input logic [6:0] eg, input logic es);
        comparisons++;
        if ({per_grant, cpu_stall} !== {eg, es}) begin
            miscompares++;
            $display("ERROR grant_stall expected %h %h seen %h %h", eg, es, per_grant, cpu_stall);
        end
    endtask : chk_arb
    // Write with both channels offered together, bready held until bvalid
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        chk_val("bresp", 32'(er), 32'(s_axi_bresp));
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        chk_val("rresp", 32'(er), 32'(s_axi_rresp));
        chk_val("rdata", ed, s_axi_rdata);
    endtask : rd
    // Keyed lock change, three writes back to back
    task automatic set_lock(input logic v);
        wr(SAR_OFS_LOCK, 32'(SAR_KEY1), SAR_RESP_OKAY);
        wr(SAR_OFS_LOCK, 32'(SAR_KEY2), SAR_RESP_OKAY);
        wr(SAR_OFS_LOCK, 32'(v), SAR_RESP_OKAY);
    endtask : set_lock
    task automatic arb(input sar_row_s r);
        @(posedge aclk);
        {cpu_isr_active, cpu_flash_access, cpu_data_access, flash_op_busy, eeprom_op_busy} <= r.cpu;
        {want, want_tgt} <= {r.req, r.tgt};
        @(negedge aclk);
        chk_arb(r.g, r.st);
        @(posedge aclk);
        want <= 7'h00;
        @(posedge aclk);
    endtask : arb
    // Main sequence
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {16'h0000, 32'h0, 4'hF};
        {cpu_isr_active, cpu_flash_access, cpu_data_access, flash_op_busy, eeprom_op_busy} = 5'h00;
        {want, want_tgt} = 21'h0;
        miscompares = 0;
        comparisons = 0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        for (i = 0; i < 9; i++) rd(SAR_OFS_PRIO0 + 8'(4 * i), 32'h7, SAR_RESP_OKAY);
        wr(SAR_OFS_PRIO0, 32'hFFFFFFF8, SAR_RESP_OKAY);
        rd(SAR_OFS_PRIO0, 32'h0, SAR_RESP_OKAY);
        for (i = 0; i < 9; i++) wr(SAR_OFS_PRIO0 + 8'(4 * i), 32'(prio[i]), SAR_RESP_OKAY);
        for (i = 0; i < 9; i++) rd(SAR_OFS_PRIO0 + 8'(4 * i), 32'(prio[i]), SAR_RESP_OKAY);
        wr(8'h30, 32'h1, SAR_RESP_SLVERR);
        rd(8'h30, 32'h0, SAR_RESP_SLVERR);
        wr(SAR_OFS_STAT, 32'hFF, SAR_RESP_OKAY);
        rd(SAR_OFS_STAT, 32'h0, SAR_RESP_OKAY);
        arb('{5'h00, 7'h01, 14'h0020, 7'h00, 1'h0});
        wr(SAR_OFS_LOCK, 32'(SAR_KEY1), SAR_RESP_OKAY);
        wr(SAR_OFS_LOCK, 32'h12, SAR_RESP_OKAY);
        wr(SAR_OFS_LOCK, 32'h1, SAR_RESP_OKAY);
        rd(SAR_OFS_LOCK, 32'h0, SAR_RESP_OKAY);
        set_lock(1'h1);
        rd(SAR_OFS_LOCK, 32'h1, SAR_RESP_OKAY);
        wr(SAR_OFS_PRIO0, 32'h0, SAR_RESP_OKAY);
        rd(SAR_OFS_PRIO0, 32'h2, SAR_RESP_OKAY);
        for (i = 0; i < 12; i++) arb(rows[i]);
        set_lock(1'h0);
        rd(SAR_OFS_LOCK, 32'h0, SAR_RESP_OKAY);
        arb('{5'h00, 7'h01, 14'h0020, 7'h00, 1'h0});
        report_and_stop();
    end
    // Watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge aclk);
        miscompares++;
        report_and_stop();
    end
endmodule : sar_arbiter_tb_top
